// ---- camit_pkg.sv ----
package camit_pkg;

  // ==========================================================
  // Operations and operand forms
  typedef enum logic [4:0] {
    ADD_OP, ADD_WITH_CARRY_OP, SUBTRACT_BORROW_OP,
    BITWISE_AND_OP, BITWISE_OR_OP, BITWISE_XOR_OP,
    ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP,
    ROTATE_LEFT_OP, ROTATE_RIGHT_OP, NIBBLE_SWAP_OP,
    CLEAR_ACC_OP, INVERT_ACC_OP, DECIMAL_FIXUP_OP,
    PLUS_ONE_OP, MINUS_ONE_OP, POINTER_PLUS_ONE_OP,
    MULTIPLY_OP, DIVIDE_OP, TRANSFER_OP
  } camit_op_e;

  typedef enum logic [2:0] {
    ACC_FORM, BANK_REGISTER_FORM, DIRECT_FORM,
    POINTER_REGISTER_FORM, IMMEDIATE_FORM
  } camit_form_e;

  // ==========================================================
  // Widths
  localparam int DATA_W = 8;
  localparam int PTR_W  = 16;
  localparam int LEN_W  = 2;
  localparam int MC_W   = 3;
  localparam int ELAP_W = 16;

  // ==========================================================
  // Timing in machine cycles and oscillator periods
  localparam int OSC_PER_MC   = 12;
  localparam logic [MC_W-1:0] MC_ONE  = 3'h1;
  localparam logic [MC_W-1:0] MC_TWO  = 3'h2;
  localparam logic [MC_W-1:0] MC_FOUR = 3'h4;
  localparam int PER_SHORT = 12;
  localparam int PER_LONG  = 24;
  localparam int PER_MULDIV = 48;

  // ==========================================================
  // Encoded lengths in bytes
  localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
  localparam logic [LEN_W-1:0] LEN_TWO   = 2'h2;
  localparam logic [LEN_W-1:0] LEN_THREE = 2'h3;

  // ==========================================================
  // Reset values and decimal fixup constants
  localparam logic [DATA_W-1:0] BYTE_RST   = 8'h00;
  localparam logic [PTR_W-1:0]  PTR_RST    = 16'h0000;
  localparam logic [3:0]        BCD_MAX    = 4'h9;
  localparam logic [DATA_W-1:0] FIX_LOW    = 8'h06;
  localparam logic [DATA_W-1:0] FIX_HIGH   = 8'h60;

endpackage : camit_pkg

// ---- camit_alu_if.sv ----
interface camit_alu_if
  import camit_pkg::*;
();
  camit_op_e         op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] breg;
  logic [PTR_W-1:0]  ptr;
  logic              cy_in;
  logic              ac_in;
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] res_b;
  logic [PTR_W-1:0]  res_ptr;
  logic              cy;
  logic              ov;
  logic              ac;

  modport core (
    output op, a, b, breg, ptr, cy_in, ac_in,
    input  res, res_b, res_ptr, cy, ov, ac
  );
  modport alu (
    input  op, a, b, breg, ptr, cy_in, ac_in,
    output res, res_b, res_ptr, cy, ov, ac
  );
endinterface : camit_alu_if

// ---- camit_alu.sv ----
module camit_alu
  import camit_pkg::*;
(
  camit_alu_if.alu bus
);

  logic              cin;
  logic [DATA_W:0]   sum9;
  logic [4:0]        sum_lo;
  logic [DATA_W:0]   dif9;
  logic [4:0]        dif_lo;
  logic [2*DATA_W-1:0] prod;
  logic [DATA_W:0]   fix1;
  logic [DATA_W:0]   fix2;

  assign cin    = (bus.op == ADD_WITH_CARRY_OP) & bus.cy_in;
  assign sum9   = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, cin};
  assign sum_lo = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]}
                + {4'h0, cin};
  assign dif9   = {1'b0, bus.a} - {1'b0, bus.b}
                - {8'h00, bus.cy_in};
  assign dif_lo = {1'b0, bus.a[3:0]} - {1'b0, bus.b[3:0]}
                - {4'h0, bus.cy_in};
  assign prod   = bus.a * bus.breg;
  assign fix1   = ((bus.a[3:0] > BCD_MAX) | bus.ac_in)
                ? {1'b0, bus.a} + {1'b0, FIX_LOW} : {1'b0, bus.a};
  assign fix2   = ((fix1[7:4] > BCD_MAX) | fix1[8] | bus.cy_in)
                ? {1'b0, fix1[7:0]} + {1'b0, FIX_HIGH} : fix1;

  always_comb begin
    bus.res     = bus.a;
    bus.res_b   = bus.breg;
    bus.res_ptr = bus.ptr;
    bus.cy      = bus.cy_in;
    bus.ov      = 1'b0;
    bus.ac      = bus.ac_in;
    case (bus.op)
      ADD_OP, ADD_WITH_CARRY_OP: begin
        bus.res = sum9[7:0];
        bus.cy  = sum9[8];
        bus.ac  = sum_lo[4];
        bus.ov  = ~(bus.a[7] ^ bus.b[7]) & (bus.a[7] ^ sum9[7]);
      end
      SUBTRACT_BORROW_OP: begin
        bus.res = dif9[7:0];
        bus.cy  = dif9[8];
        bus.ac  = dif_lo[4];
        bus.ov  = (bus.a[7] ^ bus.b[7]) & (bus.a[7] ^ dif9[7]);
      end
      BITWISE_AND_OP:        bus.res = bus.a & bus.b;
      BITWISE_OR_OP:         bus.res = bus.a | bus.b;
      BITWISE_XOR_OP:        bus.res = bus.a ^ bus.b;
      ROTATE_LEFT_CARRY_OP:  {bus.cy, bus.res} = {bus.a, bus.cy_in};
      ROTATE_RIGHT_CARRY_OP: {bus.res, bus.cy} = {bus.cy_in, bus.a};
      ROTATE_LEFT_OP:        bus.res = {bus.a[6:0], bus.a[7]};
      ROTATE_RIGHT_OP:       bus.res = {bus.a[0], bus.a[7:1]};
      NIBBLE_SWAP_OP:        bus.res = {bus.a[3:0], bus.a[7:4]};
      CLEAR_ACC_OP:          bus.res = BYTE_RST;
      INVERT_ACC_OP:         bus.res = ~bus.a;
      // Carry is only ever set here, never cleared
      DECIMAL_FIXUP_OP: begin
        bus.res = fix2[7:0];
        bus.cy  = bus.cy_in | fix2[8] | fix1[8];
      end
      PLUS_ONE_OP:  bus.res = bus.a + 8'h01;
      MINUS_ONE_OP: bus.res = bus.a - 8'h01;
      POINTER_PLUS_ONE_OP: bus.res_ptr = bus.ptr + 16'h0001;
      MULTIPLY_OP: begin
        bus.res   = prod[7:0];
        bus.res_b = prod[15:8];
        bus.cy    = 1'b0;
        bus.ov    = |prod[15:8];
      end
      // Divide by zero leaves both operands untouched
      DIVIDE_OP: begin
        bus.cy = 1'b0;
        bus.ov = (bus.breg == BYTE_RST);
        if (bus.breg != BYTE_RST) begin
          bus.res   = bus.a / bus.breg;
          bus.res_b = bus.a % bus.breg;
        end
      end
      TRANSFER_OP: bus.res = bus.b;
      default:     bus.res = bus.a;
    endcase
  end

endmodule : camit_alu

// ---- camit_core.sv ----
// Overview of operation
// - Add: four sources, direct/immediate two bytes
// - Add with carry sums operand and carry
// - Subtract with borrow removes operand and carry
// - AND register into accumulator, one byte
// - AND accumulator into direct byte, two bytes
// - AND immediate into direct, three bytes, 24
// - OR direct into accumulator, two bytes
// - OR immediate into direct, three bytes, 24
// - XOR register into accumulator, one byte
// - XOR immediate into direct, three bytes, 24
// - Rotate carry and accumulator left once
// - Rotate carry and accumulator right once
// - Swap accumulator nibbles, one byte
// - Load immediate into accumulator, two bytes
// - Direct into bank register: 24 periods
// - Bank register into direct: 24 periods
// - Direct to direct: three bytes, 24
// - Indirect into direct: two bytes, 24
// - Immediate into bank register: 12 periods
// - Arithmetic sets three flags; rotates through carry set carry only
module camit_core
  import camit_pkg::*;
#(
  parameter int CLKS_PER_OSC = 1
) (
  // Clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_ce,
  // Instruction request
  input  wire logic              i_valid,
  input  wire camit_op_e         i_op,
  input  wire camit_form_e       i_dst,
  input  wire camit_form_e       i_src,
  // Operand values
  input  wire logic [DATA_W-1:0] i_acc,
  input  wire logic [DATA_W-1:0] i_dst_val,
  input  wire logic [DATA_W-1:0] i_src_val,
  input  wire logic [DATA_W-1:0] i_breg,
  input  wire logic [PTR_W-1:0]  i_data_pointer,
  input  wire logic              i_cy,
  input  wire logic              i_ac,
  // Progress and timing
  output logic                   o_busy,
  output logic                   o_done,
  output logic                   o_bad,
  output logic [LEN_W-1:0]       o_len,
  output logic [MC_W-1:0]        o_mcycles,
  // Results
  output logic [DATA_W-1:0]      o_acc,
  output logic                   o_acc_we,
  output logic [DATA_W-1:0]      o_dst_data,
  output logic                   o_dst_we,
  output logic [DATA_W-1:0]      o_breg,
  output logic                   o_breg_we,
  output logic [PTR_W-1:0]       o_data_pointer,
  output logic                   o_data_pointer_we,
  output logic                   o_cy,
  output logic                   o_cy_we,
  output logic                   o_ov,
  output logic                   o_ov_we,
  output logic                   o_ac,
  output logic                   o_ac_we
);

  localparam int PRE_W = $clog2(CLKS_PER_OSC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CLKS_PER_OSC - 1);

  // ==========================================================
  // Latched instruction
  camit_op_e         op_reg;
  camit_form_e       dst_reg;
  camit_form_e       src_reg;
  logic [DATA_W-1:0] acc_reg, dstv_reg, srcv_reg, breg_reg;
  logic [PTR_W-1:0]  ptr_reg;
  logic              cy_reg, ac_reg, legal_reg;
  logic [LEN_W-1:0]  len_reg;
  logic [MC_W-1:0]   mc_reg;
  logic [PRE_W-1:0]  pre_reg;
  logic [5:0]        osc_reg;
  logic [5:0]        per_last;

  // ==========================================================
  // Length and machine-cycle decode of the request
  logic             legal_next;
  logic [LEN_W-1:0] len_next;
  logic [MC_W-1:0]  mc_next;
  wire logic src_wide = (i_src == DIRECT_FORM) |
                        (i_src == IMMEDIATE_FORM);
  wire logic src_data = (i_src != ACC_FORM);
  wire logic acc_dst  = (i_dst == ACC_FORM);
  wire logic is_logic = (i_op == BITWISE_AND_OP) |
                        (i_op == BITWISE_OR_OP) |
                        (i_op == BITWISE_XOR_OP);

  always_comb begin
    legal_next = 1'b1;
    len_next   = LEN_ONE;
    mc_next    = MC_ONE;
    case (i_op)
      ADD_OP, ADD_WITH_CARRY_OP, SUBTRACT_BORROW_OP,
      BITWISE_AND_OP, BITWISE_OR_OP, BITWISE_XOR_OP: begin
        if (acc_dst) begin
          legal_next = src_data;
          len_next   = src_wide ? LEN_TWO : LEN_ONE;
        end else if (is_logic && i_dst == DIRECT_FORM &&
                     i_src == ACC_FORM) begin
          len_next = LEN_TWO;
        end else if (is_logic && i_dst == DIRECT_FORM &&
                     i_src == IMMEDIATE_FORM) begin
          len_next = LEN_THREE;
          mc_next  = MC_TWO;
        end else begin
          legal_next = 1'b0;
        end
      end
      ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP,
      ROTATE_LEFT_OP, ROTATE_RIGHT_OP, NIBBLE_SWAP_OP,
      CLEAR_ACC_OP, INVERT_ACC_OP, DECIMAL_FIXUP_OP:
        legal_next = acc_dst;
      PLUS_ONE_OP, MINUS_ONE_OP: begin
        legal_next = (i_dst != IMMEDIATE_FORM);
        len_next   = (i_dst == DIRECT_FORM) ? LEN_TWO : LEN_ONE;
      end
      POINTER_PLUS_ONE_OP: mc_next = MC_TWO;
      MULTIPLY_OP, DIVIDE_OP: mc_next = MC_FOUR;
      TRANSFER_OP: begin
        case (i_dst)
          ACC_FORM: begin
            legal_next = src_data;
            len_next   = src_wide ? LEN_TWO : LEN_ONE;
          end
          BANK_REGISTER_FORM: begin
            legal_next = (i_src != BANK_REGISTER_FORM) &&
                         (i_src != POINTER_REGISTER_FORM);
            len_next   = src_wide ? LEN_TWO : LEN_ONE;
            mc_next    = (i_src == DIRECT_FORM) ? MC_TWO : MC_ONE;
          end
          DIRECT_FORM: begin
            len_next = (i_src == DIRECT_FORM ||
                        i_src == IMMEDIATE_FORM) ? LEN_THREE
                                                 : LEN_TWO;
            mc_next  = (i_src == ACC_FORM) ? MC_ONE : MC_TWO;
          end
          POINTER_REGISTER_FORM: begin
            legal_next = (i_src == ACC_FORM) || src_wide;
            len_next   = src_wide ? LEN_TWO : LEN_ONE;
            mc_next    = (i_src == DIRECT_FORM) ? MC_TWO : MC_ONE;
          end
          default: legal_next = 1'b0;
        endcase
      end
      default: legal_next = 1'b0;
    endcase
  end

  // ==========================================================
  // Datapath
  camit_alu_if alu_bus ();

  assign alu_bus.op    = op_reg;
  assign alu_bus.a     = (dst_reg == ACC_FORM) ? acc_reg : dstv_reg;
  assign alu_bus.b     = (src_reg == ACC_FORM) ? acc_reg : srcv_reg;
  assign alu_bus.breg  = breg_reg;
  assign alu_bus.ptr   = ptr_reg;
  assign alu_bus.cy_in = cy_reg;
  assign alu_bus.ac_in = ac_reg;

  camit_alu u_alu (
    .bus (alu_bus)
  );

  // ==========================================================
  // Sequencing
  wire logic accept  = i_ce & i_valid & ~o_busy;
  wire logic osc_end = (pre_reg == PRE_LAST);
  assign per_last = 6'(int'(mc_reg) * OSC_PER_MC - 1);
  wire logic finish  = o_busy & osc_end & (osc_reg == per_last);
  wire logic arith   = (op_reg == ADD_OP) |
                       (op_reg == ADD_WITH_CARRY_OP) |
                       (op_reg == SUBTRACT_BORROW_OP);
  wire logic rot_c   = (op_reg == ROTATE_LEFT_CARRY_OP) |
                       (op_reg == ROTATE_RIGHT_CARRY_OP) |
                       (op_reg == DECIMAL_FIXUP_OP);
  wire logic muldiv  = (op_reg == MULTIPLY_OP) |
                       (op_reg == DIVIDE_OP);
  wire logic no_wr   = arith | muldiv | rot_c |
                       (op_reg == POINTER_PLUS_ONE_OP);
  wire logic to_acc  = legal_reg & (dst_reg == ACC_FORM) &
                       (op_reg != POINTER_PLUS_ONE_OP) & ~muldiv;
  wire logic to_dst  = legal_reg & (dst_reg != ACC_FORM) & ~no_wr;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      op_reg    <= ADD_OP;
      dst_reg   <= ACC_FORM;
      src_reg   <= ACC_FORM;
      acc_reg   <= BYTE_RST;
      dstv_reg  <= BYTE_RST;
      srcv_reg  <= BYTE_RST;
      breg_reg  <= BYTE_RST;
      ptr_reg   <= PTR_RST;
      cy_reg    <= 1'b0;
      ac_reg    <= 1'b0;
      legal_reg <= 1'b0;
      len_reg   <= LEN_ONE;
      mc_reg    <= MC_ONE;
    end else if (accept) begin
      op_reg    <= i_op;
      dst_reg   <= i_dst;
      src_reg   <= i_src;
      acc_reg   <= i_acc;
      dstv_reg  <= i_dst_val;
      srcv_reg  <= i_src_val;
      breg_reg  <= i_breg;
      ptr_reg   <= i_data_pointer;
      cy_reg    <= i_cy;
      ac_reg    <= i_ac;
      legal_reg <= legal_next;
      len_reg   <= len_next;
      // Bad requests still spend one machine cycle
      mc_reg    <= legal_next ? mc_next : MC_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_busy  <= 1'b0;
      pre_reg <= '0;
      osc_reg <= '0;
    end else if (i_ce) begin
      if (accept) begin
        o_busy  <= 1'b1;
        pre_reg <= '0;
        osc_reg <= '0;
      end else if (o_busy) begin
        o_busy  <= ~finish;
        pre_reg <= osc_end ? '0 : pre_reg + 1'b1;
        osc_reg <= osc_end ? osc_reg + 6'h01 : osc_reg;
      end
    end
  end

  // ==========================================================
  // Result registers, loaded on every enabled cycle; done and write enables pulse after the finishing cycle
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
      o_bad <= 1'b0;
      o_len <= LEN_ONE;
      o_mcycles <= MC_ONE;
      o_acc <= BYTE_RST;
      o_acc_we <= 1'b0;
      o_dst_data <= BYTE_RST;
      o_dst_we <= 1'b0;
      o_breg <= BYTE_RST;
      o_breg_we <= 1'b0;
      o_data_pointer <= PTR_RST;
      o_data_pointer_we <= 1'b0;
      {o_cy, o_ov, o_ac} <= 3'h0;
      {o_cy_we, o_ov_we, o_ac_we} <= 3'h0;
    end else if (i_ce) begin
      o_done            <= finish;
      o_bad             <= finish & ~legal_reg;
      o_len             <= len_reg;
      o_mcycles         <= mc_reg;
      o_acc             <= alu_bus.res;
      o_acc_we          <= finish & (to_acc | (muldiv & legal_reg));
      o_dst_data        <= alu_bus.res;
      o_dst_we          <= finish & to_dst;
      o_breg            <= alu_bus.res_b;
      o_breg_we         <= finish & muldiv & legal_reg;
      o_data_pointer    <= alu_bus.res_ptr;
      o_data_pointer_we <= finish & legal_reg &
                           (op_reg == POINTER_PLUS_ONE_OP);
      o_cy              <= alu_bus.cy;
      o_ov              <= alu_bus.ov;
      o_ac              <= alu_bus.ac;
      o_cy_we <= finish & legal_reg & (arith | rot_c | muldiv);
      o_ov_we <= finish & legal_reg & (arith | muldiv);
      o_ac_we <= finish & legal_reg & arith;
    end
  end

  // ==========================================================
  // Checks
  logic [ELAP_W-1:0] elap_reg;
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      elap_reg <= '0;
    end else if (i_ce) begin
      elap_reg <= accept ? '0 : (o_busy ? elap_reg + 1'b1 : elap_reg);
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_done_latency: assert property (
    $rose(o_done) |-> elap_reg ==
      ELAP_W'(int'(o_mcycles) * OSC_PER_MC * CLKS_PER_OSC))
    else $error("done not at machine cycle boundary");
  a_add_forms: assert property (
    accept && i_op == ADD_OP && i_dst == ACC_FORM &&
    i_src == IMMEDIATE_FORM |=> len_reg == LEN_TWO &&
    mc_reg == MC_ONE)
    else $error("add immediate length or time wrong");
  a_add_with_carry_op_sum: assert property (
    $rose(o_done) && o_acc_we && op_reg == ADD_WITH_CARRY_OP |->
    {o_cy, o_acc} == {1'b0, acc_reg} + {1'b0, srcv_reg}
                     + {8'h00, cy_reg})
    else $error("add with carry sum wrong");
  a_subtract_borrow_op_diff: assert property (
    $rose(o_done) && o_acc_we && op_reg == SUBTRACT_BORROW_OP
    |-> o_acc == acc_reg - srcv_reg - {7'h00, cy_reg})
    else $error("subtract with borrow wrong");
  a_and_direct: assert property (
    accept && i_op == BITWISE_AND_OP && i_dst == DIRECT_FORM &&
    i_src == IMMEDIATE_FORM |=> len_reg == LEN_THREE &&
    mc_reg == MC_TWO)
    else $error("and immediate to direct timing wrong");
  a_rot_left: assert property (
    $rose(o_done) && o_acc_we && op_reg == ROTATE_LEFT_CARRY_OP
    |-> {o_cy, o_acc} == {acc_reg, cy_reg} && o_cy_we && !o_ov_we)
    else $error("rotate left through carry wrong");
  a_swap_nib: assert property (
    $rose(o_done) && o_acc_we && op_reg == NIBBLE_SWAP_OP
    |-> o_acc == {acc_reg[3:0], acc_reg[7:4]} && !o_cy_we)
    else $error("nibble swap wrong");
  a_dir_to_reg: assert property (
    accept && i_op == TRANSFER_OP && i_dst == BANK_REGISTER_FORM
    && i_src == DIRECT_FORM |=> len_reg == LEN_TWO &&
    mc_reg == MC_TWO ##1 o_busy [*8])
    else $error("direct to register timing wrong");
  a_dir_dir: assert property (
    accept && i_op == TRANSFER_OP && i_dst == DIRECT_FORM &&
    i_src == DIRECT_FORM |=> len_reg == LEN_THREE &&
    mc_reg == MC_TWO)
    else $error("direct to direct timing wrong");
  a_mul_time: assert property (
    accept && i_op == MULTIPLY_OP |=> mc_reg == MC_FOUR &&
    len_reg == LEN_ONE)
    else $error("multiply timing wrong");

endmodule : camit_core

// ---- test_cpu_alu_move_instr_timing.sv ----
module test_cpu_alu_move_instr_timing
  import camit_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and observed signals
  logic              i_clk, i_resetn, i_ce, i_valid, i_cy, i_ac;
  camit_op_e         i_op;
  camit_form_e       i_dst, i_src;
  logic [DATA_W-1:0] i_acc, i_dst_val, i_src_val, i_breg;
  logic [PTR_W-1:0]  i_dp;
  logic              o_busy, o_done, o_bad, o_acc_we, o_dst_we;
  logic              o_breg_we, o_dp_we, o_cy, o_cy_we, o_ov, o_ov_we;
  logic              o_ac, o_ac_we;
  logic [LEN_W-1:0]  o_len;
  logic [MC_W-1:0]   o_mcycles;
  logic [DATA_W-1:0] o_acc, o_dst_data, o_breg;
  logic [PTR_W-1:0]  o_dp;
  int                error_cnt = 0;
  int                comparisons = 0;
  logic              exp_bad = 1'b0;

  camit_core #(.CLKS_PER_OSC(1)) camit_core_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_valid(i_valid),
    .i_op(i_op), .i_dst(i_dst), .i_src(i_src), .i_acc(i_acc),
    .i_dst_val(i_dst_val), .i_src_val(i_src_val), .i_breg(i_breg),
    .i_data_pointer(i_dp), .i_cy(i_cy), .i_ac(i_ac), .o_busy(o_busy),
    .o_done(o_done), .o_bad(o_bad), .o_len(o_len),
    .o_mcycles(o_mcycles), .o_acc(o_acc), .o_acc_we(o_acc_we),
    .o_dst_data(o_dst_data), .o_dst_we(o_dst_we), .o_breg(o_breg),
    .o_breg_we(o_breg_we), .o_data_pointer(o_dp),
    .o_data_pointer_we(o_dp_we), .o_cy(o_cy), .o_cy_we(o_cy_we),
    .o_ov(o_ov), .o_ov_we(o_ov_we), .o_ac(o_ac), .o_ac_we(o_ac_we)
  );

  always #2.5 i_clk = ~i_clk;

  // ==========================================================
  // Reporting
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // One instruction; clock enable held low for gap cycles.
  // A second request is raised while busy and must be ignored.
  task automatic issue(input camit_op_e op, input camit_form_e d, s,
                       input logic [7:0] a, dv, sv, input logic c,
                       input int gap, input logic [1:0] len,
                       input logic [2:0] mc);
    int n;
    int k;
    n = 0;
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_dst <= d;
    i_src <= s;
    i_acc <= a;
    i_dst_val <= dv;
    i_src_val <= sv;
    i_cy <= c;
    @(posedge i_clk);
    i_valid <= 1'b0;
    i_ce <= (gap == 0);
    for (k = 0; k < 400; k++) begin
      @(posedge i_clk);
      if (i_ce) n++;
      i_ce <= (k + 1 >= gap);
      i_valid <= (k == 2);
      if (k == 2) i_op <= MULTIPLY_OP;
      #1;
      if (o_done === 1'b1) break;
    end
    if (o_done !== 1'b1) begin
      chk("done", 16'h1, {15'h0, o_done});
      test_done();
    end
    chk("cycles", 16'(12 * mc), 16'(n));
    chk("len", len, o_len);
    chk("mcycles", mc, o_mcycles);
    chk("bad", 16'(exp_bad), o_bad);
  endtask : issue

  task automatic chk_out(input logic to_acc, input logic [7:0] e);
    chk("acc_we", to_acc, o_acc_we);
    chk("dst_we", !to_acc, o_dst_we);
    chk("result", e, to_acc ? o_acc : o_dst_data);
  endtask : chk_out

  task automatic chk_arith(input logic sub, input logic [7:0] a, b,
                           input logic c);
    logic [8:0] r;
    logic [4:0] h;
    logic       v;
    r = sub ? {1'b0, a} - {1'b0, b} - 9'(c) : {1'b0, a} + {1'b0, b} + 9'(c);
    h = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c)
            : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c);
    v = ((a[7] ^ b[7]) == sub) && (r[7] != a[7]);
    chk_out(1'b1, r[7:0]);
    chk("cy", {1'b1, r[8]}, {o_cy_we, o_cy});
    chk("ov", {1'b1, v}, {o_ov_we, o_ov});
    chk("ac", {1'b1, h[4]}, {o_ac_we, o_ac});
  endtask : chk_arith

  // Fixed operands: acc c5, destination 5a, source 0f
  task automatic run(input camit_op_e op, input camit_form_e d, s,
                     input logic [1:0] len, input logic [2:0] mc,
                     input logic [7:0] e);
    issue(op, d, s, 8'hc5, 8'h5a, 8'h0f, 1'b0, 0, len, mc);
    chk_out(d == ACC_FORM, e);
  endtask : run

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    #1;
    chk("rst_len", 16'h1, o_len);
    chk("rst_mc", 16'h1, o_mcycles);
    chk("rst_done", 16'h0, {o_done, o_busy});
  endtask : t_reset

  task automatic t_add();
    camit_form_e f[4];
    int i;
    f = '{BANK_REGISTER_FORM, DIRECT_FORM, POINTER_REGISTER_FORM,
          IMMEDIATE_FORM};
    // Carry in is set to show plain add ignores it
    for (i = 0; i < 4; i++) begin
      issue(ADD_OP, ACC_FORM, f[i], 8'h7f, 8'h00, 8'(i + 1), 1'b1, i,
            (i % 2 == 1) ? 2'h2 : 2'h1, 3'h1);
      chk_arith(1'b0, 8'h7f, 8'(i + 1), 1'b0);
    end
  endtask : t_add

  task automatic t_carry_ops();
    issue(ADD_WITH_CARRY_OP, ACC_FORM, BANK_REGISTER_FORM, 8'hff, 8'h00,
          8'h00, 1'b1, 0, 2'h1, 3'h1);
    chk_arith(1'b0, 8'hff, 8'h00, 1'b1);
    issue(ADD_WITH_CARRY_OP, ACC_FORM, POINTER_REGISTER_FORM, 8'h38,
          8'h00, 8'h47, 1'b1, 0, 2'h1, 3'h1);
    chk_arith(1'b0, 8'h38, 8'h47, 1'b1);
    issue(SUBTRACT_BORROW_OP, ACC_FORM, IMMEDIATE_FORM, 8'h80, 8'h00,
          8'h01, 1'b1, 0, 2'h2, 3'h1);
    chk_arith(1'b1, 8'h80, 8'h01, 1'b1);
    issue(SUBTRACT_BORROW_OP, ACC_FORM, IMMEDIATE_FORM, 8'h00, 8'h00,
          8'h00, 1'b1, 2, 2'h2, 3'h1);
    chk_arith(1'b1, 8'h00, 8'h00, 1'b1);
  endtask : t_carry_ops

  task automatic t_logic();
    run(BITWISE_AND_OP, ACC_FORM, BANK_REGISTER_FORM, 2'h1, 3'h1,
        8'h05);
    run(BITWISE_AND_OP, DIRECT_FORM, ACC_FORM, 2'h2, 3'h1,
        8'h40);
    run(BITWISE_AND_OP, DIRECT_FORM, IMMEDIATE_FORM, 2'h3, 3'h2,
        8'h0a);
    run(BITWISE_OR_OP, ACC_FORM, DIRECT_FORM, 2'h2, 3'h1,
        8'hcf);
    run(BITWISE_OR_OP, DIRECT_FORM, IMMEDIATE_FORM, 2'h3, 3'h2,
        8'h5f);
    run(BITWISE_XOR_OP, ACC_FORM, BANK_REGISTER_FORM, 2'h1, 3'h1,
        8'hca);
    run(BITWISE_XOR_OP, DIRECT_FORM, IMMEDIATE_FORM, 2'h3, 3'h2,
        8'h55);
    chk("logic_cy_we", 16'h0, o_cy_we);
  endtask : t_logic

  task automatic t_rotate();
    issue(ROTATE_LEFT_CARRY_OP, ACC_FORM, ACC_FORM, 8'h81, 8'h00, 8'h00,
          1'b0, 0, 2'h1, 3'h1);
    chk_out(1'b1, 8'h02);
    chk("rlc_flags", 16'h000c, {o_cy_we, o_cy, o_ov_we, o_ac_we});
    issue(ROTATE_RIGHT_CARRY_OP, ACC_FORM, ACC_FORM, 8'h02, 8'h00, 8'h00,
          1'b1, 0, 2'h1, 3'h1);
    chk_out(1'b1, 8'h81);
    chk("rrc_flags", 16'h0008, {o_cy_we, o_cy, o_ov_we, o_ac_we});
    issue(NIBBLE_SWAP_OP, ACC_FORM, ACC_FORM, 8'h3c, 8'h00, 8'h00, 1'b1,
          0, 2'h1, 3'h1);
    chk_out(1'b1, 8'hc3);
  endtask : t_rotate

  task automatic t_transfer();
    run(TRANSFER_OP, ACC_FORM, IMMEDIATE_FORM, 2'h2, 3'h1,
        8'h0f);
    run(TRANSFER_OP, BANK_REGISTER_FORM, DIRECT_FORM, 2'h2, 3'h2,
        8'h0f);
    run(TRANSFER_OP, DIRECT_FORM, BANK_REGISTER_FORM, 2'h2, 3'h2,
        8'h0f);
    run(TRANSFER_OP, DIRECT_FORM, DIRECT_FORM, 2'h3, 3'h2,
        8'h0f);
    run(TRANSFER_OP, DIRECT_FORM, POINTER_REGISTER_FORM, 2'h2, 3'h2,
        8'h0f);
    run(TRANSFER_OP, BANK_REGISTER_FORM, IMMEDIATE_FORM, 2'h2, 3'h1,
        8'h0f);
  endtask : t_transfer

  task automatic t_long();
    issue(MULTIPLY_OP, ACC_FORM, ACC_FORM, 8'h20, 8'h00, 8'h00, 1'b1, 3,
          2'h1, 3'h4);
    chk("mul_lo", 16'h0001, {o_acc, 7'h0, o_acc_we});
    chk("mul_hi", 16'h0201, {o_breg, 7'h0, o_breg_we});
    chk("mul_flags", 16'h0110,
        {3'h0, o_cy_we, 3'h0, o_ov, 3'h0, o_cy});
    // Quotient 02, remainder 05 with divisor 10
    issue(DIVIDE_OP, ACC_FORM, ACC_FORM, 8'h25, 8'h00, 8'h00, 1'b1, 0,
          2'h1, 3'h4);
    chk("div_res", 16'h0205, {o_acc, o_breg});
    chk("div_we", 16'h0011, {3'h0, o_acc_we, 3'h0, o_breg_we});
    chk("div_flags", 16'h0100,
        {3'h0, o_cy_we, 3'h0, o_ov, 3'h0, o_cy});
    issue(POINTER_PLUS_ONE_OP, ACC_FORM, ACC_FORM, 8'h00, 8'h00, 8'h00,
          1'b0, 0, 2'h1, 3'h2);
    chk("dp", 16'h0100, o_dp);
    chk("dp_we", 16'h1, o_dp_we);
  endtask : t_long

  // Illegal form: one machine cycle, nothing written
  task automatic t_bad();
    exp_bad = 1'b1;
    issue(ROTATE_LEFT_CARRY_OP, DIRECT_FORM, ACC_FORM, 8'h81, 8'h00,
          8'h00, 1'b1, 0, 2'h1, 3'h1);
    chk("bad_we", 16'h0, {o_acc_we, o_dst_we, o_cy_we});
    exp_bad = 1'b0;
  endtask : t_bad

  // ==========================================================
  // Main sequence
  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_ce = 1'b1;
    i_valid = 1'b0;
    i_op = ADD_OP;
    i_dst = ACC_FORM;
    i_src = ACC_FORM;
    i_acc = 8'h00;
    i_dst_val = 8'h00;
    i_src_val = 8'h00;
    i_breg = 8'h10;
    i_dp = 16'h00ff;
    i_cy = 1'b0;
    i_ac = 1'b0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_add();
    t_carry_ops();
    t_logic();
    t_rotate();
    t_transfer();
    t_long();
    t_bad();
    test_done();
  end
endmodule : test_cpu_alu_move_instr_timing
